// ---- pkg/abx_defines.svh ----
`ifndef ABX_DEFINES_SVH
`define ABX_DEFINES_SVH
// ==========================================================================
// bus map (byte addresses, one 32-bit word each)
`define ABX_OFF_CTRL      5'h00
`define ABX_OFF_INSTR     5'h04
`define ABX_OFF_STAT      5'h08
`define ABX_OFF_RSEL      5'h0C
`define ABX_OFF_RDATA     5'h10
// control word fields
`define ABX_CTRL_LVL_LSB  0
`define ABX_CTRL_RING_LSB 4
`define ABX_CTRL_STOP     6
`define ABX_CTRL_RST      7'h00
// status word fields
`define ABX_STAT_BUSY     0
`define ABX_STAT_SKIP     1
`define ABX_STAT_PRIV     2
`define ABX_STAT_MON      3
// ==========================================================================
// opcode matching
`define ABX_GRP_MASK      16'hF800
`define ABX_ARG_BASE      16'hF000
`define ABX_BOP_BASE      16'hF800
`define ABX_MON_MASK      16'hFF00
`define ABX_MON_BASE      16'hD600
`define ABX_BLK_MASK      16'hFF87
`define ABX_SRB_CODE      16'hD502
`define ABX_LRB_CODE      16'hD580
// register codes as in the destination field
`define ABX_RC_STS        3'h0
`define ABX_RC_D          3'h1
`define ABX_RC_P          3'h2
`define ABX_RC_B          3'h3
`define ABX_RC_L          3'h4
`define ABX_RC_A          3'h5
`define ABX_RC_T          3'h6
`define ABX_RC_X          3'h7
// status indicator positions
`define ABX_ST_PTM        3'h0
`define ABX_ST_TG         3'h1
`define ABX_ST_K          3'h2
`define ABX_ST_Z          3'h3
`define ABX_ST_Q          3'h4
`define ABX_ST_O          3'h5
`define ABX_ST_C          3'h6
`define ABX_ST_M          3'h7
// misc
`define ABX_MON_LEVEL     4'hE
`define ABX_RING_SYS      2'h2
`define ABX_BLK_LAST      3'h7
`endif

// ---- pkg/abx_pkg.sv ----
`default_nettype none
package abx_pkg;
    // ======================================================================
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ABX_IDLE  = 4'b0001,
        ABX_EXEC  = 4'b0010,
        ABX_STORE = 4'b0100,
        ABX_LOAD  = 4'b1000
    } abx_state_t;
    // bit operation sub-functions, taken from instruction bits 10..7
    typedef enum logic [3:0] {
        ABX_SK_ZERO = 4'h0, ABX_SK_ONE = 4'h1, ABX_SK_INV = 4'h2, ABX_SK_ACC = 4'h3,
        ABX_BW_CLR  = 4'h4, ABX_BW_ONE = 4'h5, ABX_BW_INV = 4'h6, ABX_BW_ACC = 4'h7,
        ABX_K_STA   = 4'h8, ABX_K_STC  = 4'h9, ABX_K_LDA  = 4'hA, ABX_K_LDC  = 4'hB,
        ABX_K_ANC   = 4'hC, ABX_K_ORC  = 4'hD, ABX_K_AND  = 4'hE, ABX_K_ORA  = 4'hF
    } abx_bop_t;
endpackage
`default_nettype wire

// ---- hdl/abx_exec.sv ----
// Behaviour
// - argument byte sign-extended to sixteen bits
// - set form replaces whole target register
// - add form adds extended argument to target
// - bits 9:8 pick B,A,T,X; bit10 adds
// - argument group recognised from octal base opcodes
// - add form updates carry and overflow like ADD
// - bit op targets register field; zero means status
// - bit number from instruction bits 6..3
// - sixteen sub-functions, accumulator visible in status
// - status holds eight named control indicators
// - four skip tests: bit zero, bit one, bit versus accumulator or its inverse
// - four bit writes: clear, set, invert, copy
// - store accumulator then clear, or inverse then set
// - accumulator loads, ANDs, ORs bit or complement
// - monitor call raises internal interrupt, level 14
// - monitor parameter sign-extended into level-14 T
// - privileged only in rings 2,3 or stop
// - block is P,X,T,A,D,L,status,B; status high zero
// - current X gives first block word address
// - store block writes ascending addresses, memory accepts
// - storing own level saves next instruction address
// - load block fills level; own P untouched
`include "abx_defines.svh"
`default_nettype none
module abx_exec #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // avalon-mm slave
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output var  logic [31:0]       avs_readdata,
    output var  logic              avs_waitrequest,
    // main memory port
    output var  logic              mem_req,
    output var  logic              mem_we,
    output var  logic [ADDR_W-1:0] mem_addr,
    output var  logic [15:0]       mem_wdata,
    input  wire logic [15:0]       mem_rdata,
    input  wire logic              mem_ack,
    // events to the sequencer and interrupt logic
    output var  logic              skip_next,
    output var  logic              mon_irq,
    output var  logic              priv_fault,
    output var  logic              instr_done
);
    import abx_pkg::*;

    // ======================================================================
    // storage
    logic [15:0]  rf [0:127];      // sixteen levels of eight registers
    abx_state_t   st;
    logic [15:0]  ir;
    logic [3:0]   ctrl_lvl;
    logic [1:0]   ctrl_ring;
    logic         ctrl_stop;
    logic [6:0]   rsel;
    logic [2:0]   cnt;
    logic         last_skip;
    logic         last_priv;
    logic         last_mon;

    // block order in memory: P,X,T,A,D,L,status,B
    function automatic logic [2:0] blk_code(input logic [2:0] n);
        case (n)
            3'h0:    blk_code = `ABX_RC_P;
            3'h1:    blk_code = `ABX_RC_X;
            3'h2:    blk_code = `ABX_RC_T;
            3'h3:    blk_code = `ABX_RC_A;
            3'h4:    blk_code = `ABX_RC_D;
            3'h5:    blk_code = `ABX_RC_L;
            3'h6:    blk_code = `ABX_RC_STS;
            default: blk_code = `ABX_RC_B;
        endcase
    endfunction

    // byte-lane merge into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ======================================================================
    // avalon slave: one wait cycle, writes stall while an instruction runs
    logic        bus_ok;
    logic        bus_wr;
    logic [31:0] rd_mux;
    assign bus_ok = (st == ABX_IDLE) || avs_read;
    assign bus_wr = avs_write && !avs_waitrequest;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `ABX_OFF_CTRL:  rd_mux = {25'h0, ctrl_stop, ctrl_ring, ctrl_lvl};
            `ABX_OFF_INSTR: rd_mux = {16'h0000, ir};
            `ABX_OFF_STAT:  rd_mux = {28'h0, last_mon, last_priv, last_skip,
                                      st != ABX_IDLE};
            `ABX_OFF_RSEL:  rd_mux = {25'h0, rsel};
            `ABX_OFF_RDATA: rd_mux = {16'h0000, rf[rsel]};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && avs_waitrequest && bus_ok) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rd_mux;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // control word and register window select
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {ctrl_stop, ctrl_ring, ctrl_lvl} <= `ABX_CTRL_RST;
            rsel <= 7'h00;
        end else if (bus_wr && avs_address == `ABX_OFF_CTRL && avs_byteenable[0]) begin
            ctrl_lvl  <= avs_writedata[`ABX_CTRL_LVL_LSB +: 4];
            ctrl_ring <= avs_writedata[`ABX_CTRL_RING_LSB +: 2];
            ctrl_stop <= avs_writedata[`ABX_CTRL_STOP];
        end else if (bus_wr && avs_address == `ABX_OFF_RSEL && avs_byteenable[0]) begin
            rsel <= avs_writedata[6:0];
        end
    end

    // ======================================================================
    // decode
    logic is_arg, is_bop, is_mon, is_srb, is_lrb, priv_ok;
    assign is_arg  = (ir & `ABX_GRP_MASK) == `ABX_ARG_BASE;
    assign is_bop  = (ir & `ABX_GRP_MASK) == `ABX_BOP_BASE;
    assign is_mon  = (ir & `ABX_MON_MASK) == `ABX_MON_BASE;
    assign is_srb  = (ir & `ABX_BLK_MASK) == `ABX_SRB_CODE;
    assign is_lrb  = (ir & `ABX_BLK_MASK) == `ABX_LRB_CODE;
    assign priv_ok = ctrl_stop || (ctrl_ring >= `ABX_RING_SYS);

    // current-level status and argument arithmetic
    logic [15:0] sext;
    logic [2:0]  arg_code;
    logic [15:0] arg_old;
    logic [16:0] arg_sum;
    logic        arg_ovf;
    logic [7:0]  sts_cur;
    logic [7:0]  sts_arg;
    assign sext    = {{8{ir[7]}}, ir[7:0]};
    assign sts_cur = rf[{ctrl_lvl, `ABX_RC_STS}][7:0];

    always_comb begin
        case (ir[9:8])
            2'h0:    arg_code = `ABX_RC_B;
            2'h1:    arg_code = `ABX_RC_A;
            2'h2:    arg_code = `ABX_RC_T;
            default: arg_code = `ABX_RC_X;
        endcase
    end
    assign arg_old = rf[{ctrl_lvl, arg_code}];
    assign arg_sum = {1'b0, arg_old} + {1'b0, sext};
    assign arg_ovf = (arg_old[15] == sext[15]) && (arg_sum[15] != arg_old[15]);

    // carry from the sum, dynamic overflow per add, static overflow sticky
    always_comb begin
        sts_arg            = sts_cur;
        sts_arg[`ABX_ST_C] = arg_sum[16];
        sts_arg[`ABX_ST_Q] = arg_ovf;
        sts_arg[`ABX_ST_O] = sts_cur[`ABX_ST_O] | arg_ovf;
    end

    // ======================================================================
    // single-bit operations
    logic [2:0]  dr;
    logic [3:0]  bn;
    abx_bop_t    sub;
    logic [15:0] bop_val;
    logic [15:0] bop_res;
    logic [7:0]  sts_bop;
    logic        bit_v, k_v, new_bit, new_k, bop_skip;
    assign dr  = ir[2:0];
    assign bn  = ir[6:3];
    assign sub = abx_bop_t'(ir[10:7]);
    // status reads as eight bits, upper byte zero
    assign bop_val = (dr == `ABX_RC_STS) ? {8'h00, sts_cur}
                                        : rf[{ctrl_lvl, dr}];
    assign bit_v   = bop_val[bn];
    assign k_v     = sts_cur[`ABX_ST_K];

    always_comb begin
        new_bit  = bit_v;
        new_k    = k_v;
        bop_skip = 1'b0;
        case (sub)
            ABX_SK_ZERO: bop_skip = !bit_v;
            ABX_SK_ONE:  bop_skip = bit_v;
            ABX_SK_INV:  bop_skip = (!bit_v) == k_v;
            ABX_SK_ACC:  bop_skip = bit_v == k_v;
            ABX_BW_CLR:  new_bit  = 1'b0;
            ABX_BW_ONE:  new_bit  = 1'b1;
            ABX_BW_INV:  new_bit  = !bit_v;
            ABX_BW_ACC:  new_bit  = k_v;
            ABX_K_STA: begin
                new_bit = k_v;
                new_k   = 1'b0;
            end
            ABX_K_STC: begin
                new_bit = !k_v;
                new_k   = 1'b1;
            end
            ABX_K_LDA:   new_k = bit_v;
            ABX_K_LDC:   new_k = !bit_v;
            ABX_K_ANC:   new_k = !bit_v & k_v;
            ABX_K_ORC:   new_k = !bit_v | k_v;
            ABX_K_AND:   new_k = bit_v & k_v;
            ABX_K_ORA:   new_k = bit_v | k_v;
            default:     new_k = k_v;
        endcase
        bop_res     = bop_val;
        bop_res[bn] = new_bit;
        // accumulator update lands after the bit write, so it wins on K itself
        sts_bop            = (dr == `ABX_RC_STS) ? bop_res[7:0] : sts_cur;
        sts_bop[`ABX_ST_K] = new_k;
    end

    // ======================================================================
    // register block transfer
    logic [3:0]  blk_lvl;
    logic        blk_own;
    logic [2:0]  sel_cnt;
    logic [2:0]  sel_code;
    logic [15:0] sel_word;
    logic [2:0]  ld_code;
    assign blk_lvl  = ir[6:3];
    assign blk_own  = blk_lvl == ctrl_lvl;
    assign sel_cnt  = (st == ABX_EXEC) ? 3'h0 : cnt + 3'h1;
    assign sel_code = blk_code(sel_cnt);
    assign ld_code  = blk_code(cnt);

    always_comb begin
        sel_word = rf[{blk_lvl, sel_code}];
        if (sel_code == `ABX_RC_STS)
            sel_word = {8'h00, sel_word[7:0]};
        else if (sel_code == `ABX_RC_P && blk_own)
            sel_word = sel_word + 16'h0001;
    end

    // ======================================================================
    // sequencer, memory port and event pulses
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st         <= ABX_IDLE;
            ir         <= 16'h0000;
            cnt        <= 3'h0;
            mem_req    <= 1'b0;
            mem_we     <= 1'b0;
            mem_addr   <= '0;
            mem_wdata  <= 16'h0000;
            skip_next  <= 1'b0;
            mon_irq    <= 1'b0;
            priv_fault <= 1'b0;
            instr_done <= 1'b0;
            last_skip  <= 1'b0;
            last_priv  <= 1'b0;
            last_mon   <= 1'b0;
        end else begin
            skip_next  <= 1'b0;
            mon_irq    <= 1'b0;
            priv_fault <= 1'b0;
            instr_done <= 1'b0;
            case (st)
                ABX_IDLE: begin
                    if (bus_wr && avs_address == `ABX_OFF_INSTR) begin
                        ir        <= merge16(ir, avs_writedata, avs_byteenable);
                        last_skip <= 1'b0;
                        last_priv <= 1'b0;
                        last_mon  <= 1'b0;
                        st        <= ABX_EXEC;
                    end
                end
                ABX_EXEC: begin
                    cnt <= 3'h0;
                    if ((is_srb || is_lrb) && !priv_ok) begin
                        priv_fault <= 1'b1;
                        last_priv  <= 1'b1;
                        instr_done <= 1'b1;
                        st         <= ABX_IDLE;
                    end else if (is_srb || is_lrb) begin
                        mem_req   <= 1'b1;
                        mem_we    <= is_srb;
                        mem_addr  <= ADDR_W'(rf[{ctrl_lvl, `ABX_RC_X}]);
                        mem_wdata <= sel_word;
                        st        <= is_srb ? ABX_STORE : ABX_LOAD;
                    end else begin
                        skip_next  <= is_bop && bop_skip;
                        last_skip  <= is_bop && bop_skip;
                        mon_irq    <= is_mon;
                        last_mon   <= is_mon;
                        instr_done <= 1'b1;
                        st         <= ABX_IDLE;
                    end
                end
                ABX_STORE, ABX_LOAD: begin
                    if (mem_ack) begin
                        if (cnt == `ABX_BLK_LAST) begin
                            mem_req    <= 1'b0;
                            instr_done <= 1'b1;
                            st         <= ABX_IDLE;
                        end else begin
                            cnt       <= cnt + 3'h1;
                            mem_addr  <= mem_addr + ADDR_W'(1);
                            mem_wdata <= sel_word;
                        end
                    end
                end
                default: st <= ABX_IDLE;
            endcase
        end
    end

    // ======================================================================
    // register file writes: data only, so no reset on the array
    always_ff @(posedge clk_sys) begin
        if (st == ABX_IDLE && bus_wr && avs_address == `ABX_OFF_RDATA) begin
            rf[rsel] <= merge16(rf[rsel], avs_writedata, avs_byteenable);
        end else if (st == ABX_EXEC && is_arg) begin
            rf[{ctrl_lvl, arg_code}] <= ir[10] ? arg_sum[15:0] : sext;
            if (ir[10])
                rf[{ctrl_lvl, `ABX_RC_STS}] <= {8'h00, sts_arg};
        end else if (st == ABX_EXEC && is_bop) begin
            if (dr != `ABX_RC_STS)
                rf[{ctrl_lvl, dr}] <= bop_res;
            rf[{ctrl_lvl, `ABX_RC_STS}] <= {8'h00, sts_bop};
        end else if (st == ABX_EXEC && is_mon) begin
            rf[{`ABX_MON_LEVEL, `ABX_RC_T}] <= sext;
        end else if (st == ABX_LOAD && mem_ack) begin
            // own program counter stays as the sequencer left it
            if (!(ld_code == `ABX_RC_P && blk_own))
                rf[{blk_lvl, ld_code}] <= (ld_code == `ABX_RC_STS)
                                          ? {8'h00, mem_rdata[7:0]} : mem_rdata;
        end
    end

    // ======================================================================
    // checks
    logic [15:0] mon_t;
    logic [15:0] cur_p;
    assign mon_t = rf[{`ABX_MON_LEVEL, `ABX_RC_T}];
    assign cur_p = rf[{ctrl_lvl, `ABX_RC_P}];

    a_arg_set_val: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st == ABX_EXEC && is_arg && !ir[10]) |=> arg_old == {{8{ir[7]}}, ir[7:0]})
        else $error("set argument value wrong");
    a_arg_add_sum: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st == ABX_EXEC && is_arg && ir[10]) |=> arg_old == $past(arg_old) + $past(sext))
        else $error("add argument sum wrong");
    a_arg_carry: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st == ABX_EXEC && is_arg && ir[10])
        |=> sts_cur[`ABX_ST_C] == $past(arg_sum[16]) && sts_cur[`ABX_ST_Q] == $past(arg_ovf))
        else $error("add argument flags wrong");
    a_bop_skip: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st == ABX_EXEC && is_bop && sub == ABX_SK_ONE && bit_v) |=> skip_next ##1 !skip_next)
        else $error("skip on set bit missing");
    a_bop_store_k: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st == ABX_EXEC && is_bop && sub == ABX_K_STA) |=> !sts_cur[`ABX_ST_K])
        else $error("accumulator not cleared");
    a_mon_load_t: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st == ABX_EXEC && is_mon) |=> mon_irq && mon_t == $past(sext))
        else $error("monitor call effect wrong");
    a_priv_block: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st == ABX_EXEC && (is_srb || is_lrb) && !priv_ok)
        |=> priv_fault && !mem_req ##1 !mem_req)
        else $error("privileged transfer not refused");
    a_blk_base: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(mem_req) |-> mem_addr == ADDR_W'($past(rf[{ctrl_lvl, `ABX_RC_X}])))
        else $error("block base not X");
    a_blk_step: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mem_req && mem_ack && cnt != `ABX_BLK_LAST) |=> mem_addr == $past(mem_addr) + 16'h0001)
        else $error("block address not ascending");
    a_blk_sts_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st == ABX_STORE && cnt == 3'h6) |-> mem_wdata[15:8] == 8'h00)
        else $error("stored status high byte set");
    a_lrb_keep_p: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st == ABX_LOAD && mem_ack && blk_own) |=> $stable(cur_p))
        else $error("own P changed by load");
endmodule
`default_nettype wire

// ---- bench/abx_mem_model.sv ----
`default_nettype none
module abx_mem_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // memory port
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic [3:0]  lat,
    output var  logic [15:0] rdata,
    output var  logic        ack
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:255];
    logic [3:0]  cnt;
    // =====================================================================
    // one ack per word after lat waits; idle data toggles so stale reads show
    always_ff @(posedge clk_sys) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (!nrst) begin
            cnt <= 4'h0;
            rdata <= 16'h0000;
        end else if (req && !ack) begin
            cnt <= cnt + 4'h1;
            if (cnt >= lat) begin
                ack <= 1'b1;
                cnt <= 4'h0;
                if (we) mem[addr[7:0]] <= wdata;
                else rdata <= mem[addr[7:0]];
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/test_arg_bitop_monitor_regblock_exec.sv ----
`include "abx_defines.svh"
`default_nettype none
module test_arg_bitop_monitor_regblock_exec;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [15:0] ir;
        logic [2:0]  rc;
        logic [15:0] ini;
        logic [15:0] ex;
        logic        sk;
    } abx_row_t;
    logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest, mem_req, mem_we, mem_ack;
    logic skip_next, mon_irq, priv_fault, instr_done;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, words, w0, v, st, n_pulse;
    logic [3:0]  lat;
    logic [2:0]  ord [0:7];
    abx_row_t    rows [0:22];
    int          n_fail, checks_done;
    abx_exec u_dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .skip_next(skip_next), .mon_irq(mon_irq),
        .priv_fault(priv_fault), .instr_done(instr_done));
    abx_mem_model u_mem (.clk_sys(clk_sys), .nrst(nrst), .req(mem_req), .we(mem_we),
        .addr(mem_addr), .wdata(mem_wdata), .lat(lat), .rdata(mem_rdata), .ack(mem_ack));
    // =====================================================================
    // clock and word counter
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (mem_req === 1'b1 && mem_ack === 1'b1) words <= words + 16'h1;
    // every skip, monitor and refusal pulse is counted, so each output is looked at
    always @(posedge clk_sys) n_pulse <= n_pulse + 16'(skip_next === 1'b1)
        + 16'(mon_irq === 1'b1) + 16'(priv_fault === 1'b1);
    // =====================================================================
    // tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // hold request until waitrequest is sampled low, then release
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        for (i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        if (i == 400) begin
            n_fail++;
            end_sim();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rw(input logic [3:0] l, input logic [2:0] c, input logic [15:0] d);
        logic [31:0] q;
        acc(1'b1, `ABX_OFF_RSEL, {25'h0, l, c}, q);
        acc(1'b1, `ABX_OFF_RDATA, {16'h0, d}, q);
    endtask
    task automatic rr(input logic [3:0] l, input logic [2:0] c, output logic [15:0] d);
        logic [31:0] q;
        acc(1'b1, `ABX_OFF_RSEL, {25'h0, l, c}, q);
        acc(1'b0, `ABX_OFF_RDATA, 32'h0, q);
        d = q[15:0];
    endtask
    // run one instruction, return the status word
    task automatic exe(input logic [15:0] ir, output logic [15:0] s);
        logic [31:0] q;
        int i;
        acc(1'b1, `ABX_OFF_INSTR, {16'h0, ir}, q);
        for (i = 0; i < 400 && instr_done !== 1'b1; i++) @(posedge clk_sys);
        if (i == 400) begin
            n_fail++;
            end_sim();
        end
        acc(1'b0, `ABX_OFF_STAT, 32'h0, q);
        s = q[15:0];
    endtask
    // =====================================================================
    // main sequence
    initial begin
        logic [31:0] q;
        logic [15:0] e;
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        lat = 4'h0;
        words = 16'h0;
        n_pulse = 16'h0;
        ord = '{3'h2, 3'h7, 3'h6, 3'h5, 3'h1, 3'h4, 3'h0, 3'h3};
        rows = '{'{16'hF0EA, 3'h3, 16'h1234, 16'hFFEA, 1'b0}, '{16'hF20B, 3'h6, 16'h5555,
            16'h000B, 1'b0}, '{16'hF37F, 3'h7, 16'h0, 16'h007F, 1'b0}, '{16'hF180, 3'h5,
            16'h0, 16'hFF80, 1'b0}, '{16'hF703, 3'h7, 16'h0010, 16'h0013, 1'b0},
            '{16'hF5FA, 3'h5, 16'h0005, 16'hFFFF, 1'b0}, '{16'hF610, 3'h6, 16'hFFF8,
            16'h0008, 1'b0}, '{16'hFAB7, 3'h7, 16'h0, 16'h0040, 1'b0}, '{16'hFB7E, 3'h6,
            16'h1234, 16'h9234, 1'b0}, '{16'hFD75, 3'h5, 16'h4000, 16'h4000, 1'b0},
            '{16'hFBEF, 3'h7, 16'h0, 16'h2000, 1'b0}, '{16'hF987, 3'h7, 16'h2000, 16'h2000,
            1'b0}, '{16'hF907, 3'h7, 16'h2000, 16'h2000, 1'b1}, '{16'hF8EF, 3'h7, 16'h2000,
            16'h2000, 1'b1}, '{16'hFC01, 3'h1, 16'h0, 16'h0001, 1'b0}, '{16'hFC8C, 3'h4,
            16'h0, 16'h0002, 1'b0}, '{16'hF890, 3'h0, 16'h0004, 16'h0004, 1'b1},
            '{16'hFD81, 3'h1, 16'h1, 16'h1, 1'b0}, '{16'hFE81, 3'h1, 16'h0, 16'h0, 1'b0},
            '{16'hFF01, 3'h1, 16'h0, 16'h0, 1'b0}, '{16'hFF81, 3'h1, 16'h1, 16'h1, 1'b0},
            '{16'hFE01, 3'h1, 16'h1, 16'h1, 1'b0}, '{16'hF981, 3'h1, 16'h0, 16'h0, 1'b1}};
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        acc(1'b0, `ABX_OFF_STAT, 32'h0, q);
        chk(q[15:0], 16'h0000);
        foreach (rows[k]) begin
            rw(4'h0, rows[k].rc, rows[k].ini);
            exe(rows[k].ir, st);
            rr(4'h0, rows[k].rc, v);
            chk(v, rows[k].ex);
            chk(st, {14'h0, rows[k].sk, 1'b0});
        end
        // add flags: overflow then carry with sticky overflow kept
        rw(4'h0, 3'h0, 16'h0000);
        rw(4'h0, 3'h7, 16'h7FFF);
        exe(16'hF701, st);
        rr(4'h0, 3'h0, v);
        chk(v, 16'h0030);
        rw(4'h0, 3'h3, 16'h0001);
        exe(16'hF4FF, st);
        rr(4'h0, 3'h0, v);
        chk(v, 16'h0060);
        exe(16'hD680, st);
        chk(st, 16'h0008);
        rr(4'hE, 3'h6, v);
        chk(v, 16'hFF80);
        // block store refused in ring 0, then taken in ring 2 with slow memory
        rw(4'h0, 3'h7, 16'h0010);
        for (int i = 0; i < 8; i++) rw(4'h3, ord[i], 16'h3A00 + 16'(i));
        w0 = words;
        exe(16'hD51A, st);
        chk(st, 16'h0004);
        chk(words - w0, 16'h0000);
        acc(1'b1, `ABX_OFF_CTRL, 32'h20, q);
        lat <= 4'h3;
        exe(16'hD51A, st);
        chk(words - w0, 16'h0008);
        for (int i = 0; i < 8; i++) begin
            e = (16'h3A00 + 16'(i)) & ((i == 6) ? 16'h00FF : 16'hFFFF);
            chk(u_mem.mem[16 + i], e);
        end
        lat <= 4'h0;
        exe(16'hD5A8, st);
        for (int i = 0; i < 8; i++) begin
            e = (16'h3A00 + 16'(i)) & ((i == 6) ? 16'h00FF : 16'hFFFF);
            rr(4'h5, ord[i], v);
            chk(v, e);
        end
        // own level: stored P is next address, load leaves P alone in stop mode
        rw(4'h0, 3'h2, 16'h0200);
        exe(16'hD502, st);
        chk(u_mem.mem[16], 16'h0201);
        acc(1'b1, `ABX_OFF_CTRL, 32'h40, q);
        exe(16'hD580, st);
        chk(st, 16'h0000);
        rr(4'h0, 3'h2, v);
        chk(v, 16'h0200);
        chk(n_pulse, 16'h0006);
        end_sim();
    end
endmodule
`default_nettype wire
